/* common/acspa_pkg.sv */
package acspa_pkg;
  // Register port: 32-bit byte address, 16-bit data words on even addresses
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam logic [31:0] CONFIG_BASE = 32'h0000_0000;
  localparam logic [31:0] KEYS_BASE = 32'h0000_1100;
  localparam logic [31:0] OTP_IF_BASE = 32'h0000_2000;
  localparam logic [31:0] OTP_CTRL_BASE = 32'h0000_2400;
  localparam logic [31:0] OTP_STS_BASE = 32'h0000_2480;
  localparam logic [31:0] SPACE_END = 32'h0000_2500;
  localparam logic [31:0] PLL_CONFIG_ONE_ADDR = 32'h0000_0002;
  localparam logic [31:0] PLL_CONFIG_TWO_ADDR = 32'h0000_0004;
  localparam logic [31:0] ALIGN_CFG_ADDR = 32'h0000_0108;
  localparam logic [31:0] ALIGN_STATUS_ADDR = 32'h0000_010A;
  localparam logic [31:0] DEVICE_ID1_ADDR = 32'h0000_0110;
  localparam logic [31:0] DEVICE_ID2_ADDR = 32'h0000_0112;
  localparam logic [15:0] PLL_CONFIG_ONE_RESET = 16'h0080;
  localparam logic [15:0] PLL_CONFIG_TWO_RESET = 16'h0008;
  localparam logic [15:0] ALIGN_CFG_RESET = 16'h0000;
  localparam logic [15:0] ALIGN_CFG_MASK = 16'h80FF;
  // Field positions
  localparam int CLK_OUT_DIS_BIT = 0;
  localparam int AUX_OUT_DIS_BIT = 1;
  localparam int ALIGN_EN_BIT = 15;
  localparam int ALIGN_STB_BIT = 7;
  localparam int ALIGN_AUTO_BIT = 6;
  localparam int ALIGN_TRIG_BIT = 5;
  localparam int ALIGN_SPEED_LSB = 3;
  localparam int ALIGN_THR_LSB = 0;
  localparam int STS_BUSY_BIT = 0;
  localparam int STS_STABLE_BIT = 1;
  localparam int STS_INVALID_BIT = 2;
  // Strap codes from the resistor level detector
  localparam logic [2:0] STRAP_PU_0R = 3'h0;
  localparam logic [2:0] STRAP_PU_4K7 = 3'h1;
  localparam logic [2:0] STRAP_PU_22K = 3'h2;
  localparam logic [2:0] STRAP_PU_100K = 3'h3;
  localparam logic [2:0] STRAP_PD_100K = 3'h4;
  localparam logic [2:0] STRAP_PD_22K = 3'h5;
  localparam logic [2:0] STRAP_PD_4K7 = 3'h6;
  localparam logic [2:0] STRAP_PD_0R = 3'h7;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // Alignment step caps in master-clock periods
  localparam logic [1:0] SPEED_ONE = 2'h0;
  localparam logic [1:0] SPEED_TEN = 2'h1;
  localparam logic [1:0] SPEED_FIFTY = 2'h2;
  localparam logic [1:0] SPEED_FULL = 2'h3;
  localparam logic [11:0] CAP_ONE = 12'h001;
  localparam logic [11:0] CAP_TEN = 12'h00A;
  localparam logic [11:0] CAP_FIFTY = 12'h032;
  typedef enum logic [1:0] {AUX_UNLOCK, AUX_OFF, AUX_CLK} acspa_aux_t;
  // Frequency codes, 0..5 = 11.2896, 12.288, 22.5792, 24.576, 45.1584, 49.152 MHz
  typedef struct packed {
    logic invalid;
    acspa_aux_t aux;
    logic [2:0] bclk_shift;
    logic [3:0] fs_shift;
    logic [2:0] freq_code;
  } acspa_cfg_t;
endpackage

/* core/acspa_core.sv */
`timescale 1ns/1ps
`default_nettype none
module acspa_core #(
  parameter int CNT_W = 12,
  parameter logic [11:0] STB_TOL = 12'h002,
  parameter logic [15:0] DEVICE_ID = 16'h0A5A, // Arbitrary value
  parameter logic [3:0] ALL_LAYER_REV = 4'h1, // Arbitrary value
  parameter logic [3:0] METAL_LAYER_REV = 4'h1 // Arbitrary value
) (
  // Clock, reset, master-clock tick
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Strap level codes
  input wire logic [2:0] aux_function_strap,
  input wire logic [2:0] bit_clock_divider_strap,
  input wire logic [2:0] frame_sync_divider_strap,
  input wire logic [2:0] output_frequency_strap,
  // Reference and unlock pins
  input wire logic ref_in,
  input wire logic freq_unlock,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_err,
  // Clock outputs
  output logic bclk_out,
  output logic fsync_out,
  output logic auxiliary_output,
  output logic clk_out_en,
  output logic [2:0] out_freq_code
);
  logic [11:0] strap_s1;
  logic [11:0] strap_s2;
  logic ref_s1, ref_s2, ref_d;
  logic unl_s1, unl_s2;
  logic [1:0] settle;
  logic strap_done;
  acspa_pkg::acspa_cfg_t cfg;
  acspa_pkg::acspa_cfg_t next_cfg;
  logic [15:0] pll_config_one, pll_config_two, align_cfg;
  logic [CNT_W-1:0] frame_cnt, next_cnt, step, remaining, offset;
  logic [CNT_W-1:0] base_len, next_step;
  logic stable, meas_new, busy, start, manual, auto_hit, wrap, outs_on;
  logic [2:0] thr;
  logic [CNT_W-1:0] thr_mclk;

  // Two-flop synchronisers; only the second stage is read
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_s1 <= 12'h000;
      strap_s2 <= 12'h000;
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      unl_s1 <= 1'b0;
      unl_s2 <= 1'b0;
    end else if (ce) begin
      strap_s1 <= {aux_function_strap, bit_clock_divider_strap, frame_sync_divider_strap, output_frequency_strap};
      strap_s2 <= strap_s1;
      ref_s1 <= ref_in;
      ref_s2 <= ref_s1;
      unl_s1 <= freq_unlock;
      unl_s2 <= unl_s1;
    end
  end

  // Strap decode; a code that maps to no setting sets the invalid flag
  always_comb begin
    next_cfg = '0;
    case (strap_s2[11:9])
      acspa_pkg::STRAP_PU_0R: next_cfg.aux = acspa_pkg::AUX_UNLOCK;
      acspa_pkg::STRAP_PD_0R: next_cfg.aux = acspa_pkg::AUX_CLK;
      default: next_cfg.aux = acspa_pkg::AUX_OFF;
    endcase
    case (strap_s2[8:6])
      acspa_pkg::STRAP_PU_0R: next_cfg.bclk_shift = 3'h4;
      acspa_pkg::STRAP_PU_4K7: next_cfg.bclk_shift = 3'h3;
      acspa_pkg::STRAP_PU_22K: next_cfg.bclk_shift = 3'h2;
      acspa_pkg::STRAP_PU_100K: next_cfg.bclk_shift = 3'h1;
      acspa_pkg::STRAP_PD_100K: next_cfg.bclk_shift = 3'h0;
      default: next_cfg.invalid = 1'b1;
    endcase
    if (strap_s2[5:3] == acspa_pkg::STRAP_PU_0R) begin
      next_cfg.invalid = 1'b1;
    end else begin
      next_cfg.fs_shift = 4'(4'hB - 4'(strap_s2[5:3]));
    end
    if (strap_s2[2:0] < acspa_pkg::STRAP_PU_22K) begin
      next_cfg.invalid = 1'b1;
    end else begin
      next_cfg.freq_code = 3'(strap_s2[2:0] - acspa_pkg::STRAP_PU_22K);
    end
  end

  // Latched once after release; a new setting needs another reset
  always_ff @(posedge clk) begin
    if (reset) begin
      settle <= 2'h0;
      strap_done <= 1'b0;
      cfg <= '0;
    end else if (ce && !strap_done) begin
      if (settle == acspa_pkg::STRAP_SETTLE) begin
        strap_done <= 1'b1;
        cfg <= next_cfg;
      end else begin
        settle <= 2'(settle + 2'h1);
      end
    end
  end

  assign outs_on = strap_done && !cfg.invalid;

  // Register port; only whole aligned words inside the five blocks are accepted
  logic in_space, in_config;
  assign in_space = (reg_addr < acspa_pkg::SPACE_END) && !reg_addr[0];
  assign in_config = reg_addr < acspa_pkg::KEYS_BASE;
  assign manual = ce && reg_wr && in_space && (reg_addr == acspa_pkg::ALIGN_CFG_ADDR)
                  && reg_wdata[acspa_pkg::ALIGN_TRIG_BIT] && reg_wdata[acspa_pkg::ALIGN_EN_BIT];

  always_ff @(posedge clk) begin
    if (reset) begin
      pll_config_one <= acspa_pkg::PLL_CONFIG_ONE_RESET;
      pll_config_two <= acspa_pkg::PLL_CONFIG_TWO_RESET;
      align_cfg <= acspa_pkg::ALIGN_CFG_RESET;
    end else if (ce && reg_wr && in_space && in_config) begin
      case (reg_addr)
        acspa_pkg::PLL_CONFIG_ONE_ADDR: pll_config_one <= reg_wdata;
        acspa_pkg::PLL_CONFIG_TWO_ADDR: pll_config_two <= reg_wdata;
        // Trigger bit is self-clearing and never stored
        acspa_pkg::ALIGN_CFG_ADDR: begin
          align_cfg <= reg_wdata & acspa_pkg::ALIGN_CFG_MASK & ~(16'h0001 << acspa_pkg::ALIGN_TRIG_BIT);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
      reg_err <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd && in_space;
      reg_err <= (reg_rd || reg_wr) && !in_space;
      reg_rdata <= 16'h0000;
      if (reg_rd && in_space) begin
        case (reg_addr)
          acspa_pkg::PLL_CONFIG_ONE_ADDR: reg_rdata <= pll_config_one;
          acspa_pkg::PLL_CONFIG_TWO_ADDR: reg_rdata <= pll_config_two;
          acspa_pkg::ALIGN_CFG_ADDR: reg_rdata <= align_cfg;
          acspa_pkg::ALIGN_STATUS_ADDR: begin
            reg_rdata <= {13'h0000, cfg.invalid, stable, busy};
          end
          acspa_pkg::DEVICE_ID1_ADDR: reg_rdata <= DEVICE_ID;
          acspa_pkg::DEVICE_ID2_ADDR: reg_rdata <= {8'h00, ALL_LAYER_REV, METAL_LAYER_REV};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Offset is the frame counter value seen at the reference rising edge
  assign meas_new = ce && ref_s2 && !ref_d;
  assign thr = align_cfg[acspa_pkg::ALIGN_THR_LSB +: 3];
  assign thr_mclk = CNT_W'(1) << ({1'b0, thr} + 4'h1);
  assign busy = (remaining != '0) || (step != '0);
  assign auto_hit = meas_new && align_cfg[acspa_pkg::ALIGN_EN_BIT] && align_cfg[acspa_pkg::ALIGN_AUTO_BIT]
                    && (frame_cnt > thr_mclk) && (!align_cfg[acspa_pkg::ALIGN_STB_BIT] || stable);
  // Without the gate a drifting phase simply retriggers after each pass
  assign start = !busy && (manual || auto_hit);

  always_ff @(posedge clk) begin
    if (reset) begin
      ref_d <= 1'b0;
      offset <= '0;
      stable <= 1'b0;
    end else if (ce) begin
      ref_d <= ref_s2;
      if (meas_new) begin
        offset <= frame_cnt;
        // Stable when two successive readings agree within tolerance
        stable <= ((frame_cnt >= offset) ? (frame_cnt - offset) : (offset - frame_cnt)) <= STB_TOL;
      end
    end
  end

  // Frame timing: base length plus the extension chosen for this frame
  assign base_len = CNT_W'(1) << cfg.fs_shift;
  assign wrap = frame_cnt >= CNT_W'(base_len + step - CNT_W'(1));
  assign next_cnt = wrap ? '0 : CNT_W'(frame_cnt + CNT_W'(1));

  always_comb begin
    next_step = remaining;
    case (align_cfg[acspa_pkg::ALIGN_SPEED_LSB +: 2])
      acspa_pkg::SPEED_ONE: if (remaining > CNT_W'(acspa_pkg::CAP_ONE)) next_step = CNT_W'(acspa_pkg::CAP_ONE);
      acspa_pkg::SPEED_TEN: if (remaining > CNT_W'(acspa_pkg::CAP_TEN)) next_step = CNT_W'(acspa_pkg::CAP_TEN);
      acspa_pkg::SPEED_FIFTY: if (remaining > CNT_W'(acspa_pkg::CAP_FIFTY)) next_step = CNT_W'(acspa_pkg::CAP_FIFTY);
      acspa_pkg::SPEED_FULL: next_step = remaining;
      default: next_step = remaining;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      frame_cnt <= '0;
      step <= '0;
      remaining <= '0;
    end else if (ce) begin
      frame_cnt <= outs_on ? next_cnt : '0;
      if (start) begin
        remaining <= manual ? offset : frame_cnt;
      end else if (wrap) begin
        step <= next_step;
        remaining <= CNT_W'(remaining - next_step);
      end
    end
  end

  // Outputs are registered; all but out_freq_code are held low while the straps are invalid
  always_ff @(posedge clk) begin
    if (reset) begin
      bclk_out <= 1'b0;
      fsync_out <= 1'b0;
      auxiliary_output <= 1'b0;
      clk_out_en <= 1'b0;
      out_freq_code <= 3'h0;
    end else if (ce) begin
      clk_out_en <= outs_on && !pll_config_one[acspa_pkg::CLK_OUT_DIS_BIT];
      out_freq_code <= cfg.freq_code;
      fsync_out <= outs_on && (next_cnt < (base_len >> 1));
      if (!outs_on) begin
        bclk_out <= 1'b0;
      end else if (cfg.bclk_shift == 3'h0) begin
        bclk_out <= !bclk_out;
      end else begin
        bclk_out <= next_cnt[cfg.bclk_shift - 3'h1];
      end
      if (!outs_on || pll_config_one[acspa_pkg::AUX_OUT_DIS_BIT]) begin
        auxiliary_output <= 1'b0;
      end else begin
        case (cfg.aux)
          acspa_pkg::AUX_UNLOCK: auxiliary_output <= unl_s2;
          acspa_pkg::AUX_CLK: auxiliary_output <= !auxiliary_output;
          default: auxiliary_output <= 1'b0;
        endcase
      end
    end
  end

  sequence s_wrap_ce;
    ce && wrap && !start;
  endsequence
  sequence s_id_read;
    ce && reg_rd && (reg_addr == acspa_pkg::DEVICE_ID1_ADDR);
  endsequence

  property p_invalid_off;
    @(posedge clk) disable iff (reset) (strap_done && cfg.invalid) |-> ##1 (!clk_out_en && !fsync_out && !bclk_out);
  endproperty
  a_invalid_off: assert property (p_invalid_off) else $error("outputs active with invalid straps");

  property p_strap_hold;
    @(posedge clk) disable iff (reset) strap_done |=> (strap_done && $stable(cfg));
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap settings changed after capture");

  property p_id_read;
    @(posedge clk) disable iff (reset) s_id_read |=> (reg_rvalid && reg_rdata == DEVICE_ID);
  endproperty
  a_id_read: assert property (p_id_read) else $error("identifier read wrong");

  property p_manual_start;
    @(posedge clk) disable iff (reset) (manual && !busy) |=> (remaining == $past(offset));
  endproperty
  a_manual_start: assert property (p_manual_start) else $error("manual trigger did not load offset");

  property p_stb_gate;
    @(posedge clk) disable iff (reset)
      (meas_new && align_cfg[acspa_pkg::ALIGN_STB_BIT] && !stable && !manual && !busy) |=> !busy;
  endproperty
  a_stb_gate: assert property (p_stb_gate) else $error("unstable offset started alignment");

  property p_speed_one;
    @(posedge clk) disable iff (reset)
      (s_wrap_ce ##0 (align_cfg[4:3] == acspa_pkg::SPEED_ONE && remaining != '0)) |=> (step == CNT_W'(1));
  endproperty
  a_speed_one: assert property (p_speed_one) else $error("speed 00 step not one");

  property p_speed_ten;
    @(posedge clk) disable iff (reset)
      (s_wrap_ce ##0 (align_cfg[4:3] == acspa_pkg::SPEED_TEN)) |=> (step <= CNT_W'(10) && step == $past(next_step));
  endproperty
  a_speed_ten: assert property (p_speed_ten) else $error("speed 01 step too large");

  property p_speed_fifty;
    @(posedge clk) disable iff (reset) (s_wrap_ce ##0 (align_cfg[4:3] == acspa_pkg::SPEED_FIFTY)) |=> step <= CNT_W'(50);
  endproperty
  a_speed_fifty: assert property (p_speed_fifty) else $error("speed 10 step too large");

  property p_speed_full;
    @(posedge clk) disable iff (reset)
      (s_wrap_ce ##0 (align_cfg[4:3] == acspa_pkg::SPEED_FULL)) |=> (remaining == '0 && step == $past(remaining));
  endproperty
  a_speed_full: assert property (p_speed_full) else $error("speed 11 did not finish in one frame");

  property p_bad_addr;
    @(posedge clk) disable iff (reset) (ce && reg_rd && reg_addr[0]) |=> (reg_err && !reg_rvalid);
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("odd address not refused");
endmodule // acspa_core
`default_nettype wire

/* sim/acspa_ref_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acspa_ref_model #(
  parameter int REF_PERIOD = 128,
  parameter int REF_PHASE = 90
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Far-side pins
  input wire logic fsync_out,
  output logic ref_in,
  // Frame length seen by the listener
  output logic [15:0] fs_len,
  output logic fs_new
);
  localparam logic [15:0] LAST = 16'(REF_PERIOD - 1);
  localparam logic [15:0] RISE = 16'(REF_PHASE);
  logic [15:0] ref_cnt;
  logic [15:0] fs_cnt;
  logic fs_d;
  // Reference restarts with reset so every run meets the same phase offset
  always_ff @(posedge clk) begin
    if (reset || ref_cnt == LAST) ref_cnt <= 16'h0000;
    else ref_cnt <= ref_cnt + 16'h0001;
  end
  assign ref_in = ref_cnt >= RISE;
  // Length of each frame, counted between rising edges of frame sync
  always_ff @(posedge clk) begin
    fs_d <= fsync_out && !reset;
    fs_new <= fsync_out && !fs_d && !reset;
    if (reset || (fsync_out && !fs_d)) fs_cnt <= 16'h0001;
    else fs_cnt <= fs_cnt + 16'h0001;
    if (fsync_out && !fs_d) fs_len <= fs_cnt;
  end
endmodule // acspa_ref_model
`default_nettype wire

/* sim/test_audio_clock_strap_and_phase_align.sv */
`timescale 1ns/1ps
`default_nettype none
module test_audio_clock_strap_and_phase_align;
  localparam logic [15:0] ID_VAL = 16'h3C3C; // Arbitrary value
  logic clk;
  logic reset;
  logic ce;
  logic [2:0] aux_function_strap;
  logic [2:0] bit_clock_divider_strap;
  logic [2:0] frame_sync_divider_strap;
  logic [2:0] output_frequency_strap;
  logic ref_in;
  logic freq_unlock;
  logic [31:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic reg_err;
  logic bclk_out;
  logic fsync_out;
  logic auxiliary_output;
  logic clk_out_en;
  logic [2:0] out_freq_code;
  logic [15:0] fs_len;
  logic fs_new;
  logic [15:0] fs_q[$];
  int n_fail = 0;
  int compares = 0;
  int e_full = 0;
  acspa_core #(.DEVICE_ID(ID_VAL), .ALL_LAYER_REV(4'h2), .METAL_LAYER_REV(4'h5)) u_acspa_core (
    .clk(clk), .reset(reset), .ce(ce), .aux_function_strap(aux_function_strap),
    .bit_clock_divider_strap(bit_clock_divider_strap), .frame_sync_divider_strap(frame_sync_divider_strap),
    .output_frequency_strap(output_frequency_strap), .ref_in(ref_in), .freq_unlock(freq_unlock),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_err(reg_err), .bclk_out(bclk_out), .fsync_out(fsync_out),
    .auxiliary_output(auxiliary_output), .clk_out_en(clk_out_en), .out_freq_code(out_freq_code));
  acspa_ref_model u_acspa_ref_model (.clk(clk), .reset(reset), .fsync_out(fsync_out), .ref_in(ref_in),
    .fs_len(fs_len), .fs_new(fs_new));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = !clk;
  end
  always @(posedge clk) if (fs_new) fs_q.push_back(fs_len);
  task automatic complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Straps are only taken after reset, so every setting needs a fresh boot
  task automatic boot(input logic [2:0] a, input logic [2:0] b, input logic [2:0] f, input logic [2:0] o);
    @(posedge clk);
    reset <= 1'b1;
    aux_function_strap <= a;
    bit_clock_divider_strap <= b;
    frame_sync_divider_strap <= f;
    output_frequency_strap <= o;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (300) @(posedge clk);
  endtask
  task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [31:0] a, output logic [15:0] q);
    acc(1'b0, a, 16'h0000);
    q = reg_rdata;
    check({15'h0000, reg_rvalid}, 16'h0001);
  endtask
  task automatic measure(input logic fs, output logic [15:0] n);
    logic p;
    logic s;
    int st;
    n = 16'h0000;
    p = 1'b1;
    st = 0;
    for (int i = 0; i < 4096 && st < 2; i++) begin
      @(negedge clk);
      s = fs ? fsync_out : bclk_out;
      if (st == 1) n = n + 16'h0001;
      if (s && !p) st++;
      p = s;
    end
  endtask
  task automatic t_regs;
    logic [15:0] q;
    boot(3'h3, 3'h0, 3'h7, 3'h3);
    rd(acspa_pkg::DEVICE_ID1_ADDR, q);
    check(q, ID_VAL);
    rd(acspa_pkg::DEVICE_ID2_ADDR, q);
    check(q, 16'h0025);
    rd(acspa_pkg::PLL_CONFIG_TWO_ADDR, q);
    check(q, 16'h0008);
    acc(1'b1, acspa_pkg::PLL_CONFIG_TWO_ADDR, 16'hA5C3);
    rd(acspa_pkg::PLL_CONFIG_TWO_ADDR, q);
    check(q, 16'hA5C3);
    rd(acspa_pkg::PLL_CONFIG_ONE_ADDR, q);
    check(q, 16'h0080);
    acc(1'b1, acspa_pkg::PLL_CONFIG_ONE_ADDR, q | 16'h0001);
    repeat (3) @(negedge clk);
    check({15'h0000, clk_out_en}, 16'h0000);
    acc(1'b1, acspa_pkg::PLL_CONFIG_ONE_ADDR, q);
    repeat (3) @(negedge clk);
    check({15'h0000, clk_out_en}, 16'h0001);
    acc(1'b1, 32'h0000_1104, 16'h00FF);
    rd(32'h0000_1104, q);
    check(q, 16'h0000);
    rd(acspa_pkg::OTP_STS_BASE, q);
    check(q, 16'h0000);
    acc(1'b0, 32'h0000_0003, 16'h0000);
    check({14'h0000, reg_err, reg_rvalid}, 16'h0002);
    acc(1'b0, acspa_pkg::SPACE_END, 16'h0000);
    check({14'h0000, reg_err, reg_rvalid}, 16'h0002);
  endtask
  task automatic t_aux;
    logic a;
    boot(3'h0, 3'h0, 3'h7, 3'h3);
    @(posedge clk);
    freq_unlock <= 1'b1;
    repeat (6) @(negedge clk);
    check({15'h0000, auxiliary_output}, 16'h0001);
    @(posedge clk);
    freq_unlock <= 1'b0;
    repeat (6) @(negedge clk);
    check({15'h0000, auxiliary_output}, 16'h0000);
    for (int c = 3; c < 5; c++) begin
      boot(3'(c), 3'h0, 3'h7, 3'h3);
      a = 1'b0;
      repeat (20) @(negedge clk) a = a | auxiliary_output;
      check({15'h0000, a}, 16'h0000);
    end
    boot(3'h7, 3'h0, 3'h7, 3'h3);
    @(negedge clk);
    a = auxiliary_output;
    @(negedge clk);
    check({15'h0000, a ^ auxiliary_output}, 16'h0001);
    // With the clock enable low even the free-running aux clock must hold
    @(posedge clk);
    ce <= 1'b0;
    @(negedge clk);
    a = auxiliary_output;
    repeat (4) @(negedge clk);
    check({15'h0000, a ^ auxiliary_output}, 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
  endtask
  // One strap swept at a time while the others hold valid codes
  task automatic t_straps;
    logic [15:0] q;
    logic [15:0] n;
    logic inv;
    logic seen;
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 8; c++) begin
        boot(3'h3, k == 0 ? 3'(c) : 3'h0, k == 1 ? 3'(c) : 3'h7, k == 2 ? 3'(c) : 3'h3);
        inv = k == 0 ? c > 4 : k == 1 ? c == 0 : c < 2;
        rd(acspa_pkg::ALIGN_STATUS_ADDR, q);
        check({15'h0000, q[acspa_pkg::STS_INVALID_BIT]}, {15'h0000, inv});
        seen = 1'b0;
        repeat (40) @(negedge clk) seen = seen | bclk_out | fsync_out;
        check({14'h0000, seen, clk_out_en}, {14'h0000, !inv, !inv});
        if (!inv && k < 2) begin
          measure(k == 1, n);
          check(n, k == 1 ? 16'(1024 >> (c - 1)) : c == 4 ? 16'h0002 : 16'(16 >> c));
        end
        if (!inv && k == 2) check({13'h0000, out_freq_code}, 16'(c - 2));
      end
    end
    @(posedge clk);
    output_frequency_strap <= 3'h2;
    repeat (8) @(negedge clk);
    check({13'h0000, out_freq_code}, 16'h0005);
  endtask
  task automatic t_align(input logic [1:0] sp, input int frames);
    logic [15:0] q;
    int n;
    int ext;
    int first;
    int cap;
    boot(3'h3, 3'h0, 3'h4, 3'h3);
    acc(1'b1, acspa_pkg::ALIGN_CFG_ADDR, {8'h80, 3'h1, sp, 3'h0});
    fs_q.delete();
    rd(acspa_pkg::ALIGN_STATUS_ADDR, q);
    check({15'h0000, q[acspa_pkg::STS_BUSY_BIT]}, 16'h0001);
    rd(acspa_pkg::ALIGN_CFG_ADDR, q);
    check(q, {8'h80, 3'h0, sp, 3'h0});
    repeat (frames * 128) @(posedge clk);
    n = 0;
    ext = 0;
    first = 0;
    foreach (fs_q[i]) begin
      if (fs_q[i] !== 16'h0080) begin
        if (n == 0) first = int'(fs_q[i]) - 128;
        n++;
        ext += int'(fs_q[i]) - 128;
      end
    end
    if (sp == 2'h3) e_full = ext;
    cap = sp == 2'h0 ? 1 : sp == 2'h1 ? 10 : sp == 2'h2 ? 50 : (e_full > 0 ? e_full : 1);
    check(16'(ext), 16'(e_full));
    check(16'(n), 16'((e_full + cap - 1) / cap));
    check(16'(first), 16'(cap < e_full ? cap : e_full));
    check(16'(e_full > 50 && e_full < 128), 16'h0001);
    rd(acspa_pkg::ALIGN_STATUS_ADDR, q);
    check({15'h0000, q[acspa_pkg::STS_BUSY_BIT]}, 16'h0000);
  endtask
  task automatic t_auto(input logic [2:0] thr, input logic stb, input int exp);
    int ext;
    boot(3'h3, 3'h0, 3'h4, 3'h3);
    acc(1'b1, acspa_pkg::ALIGN_CFG_ADDR, {8'h80, stb, 4'hB, thr});
    fs_q.delete();
    repeat (24 * 128) @(posedge clk);
    ext = 0;
    foreach (fs_q[i]) ext += int'(fs_q[i]) - 128;
    check(16'(ext), 16'(exp));
  endtask
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    aux_function_strap = 3'h3;
    bit_clock_divider_strap = 3'h0;
    frame_sync_divider_strap = 3'h7;
    output_frequency_strap = 3'h3;
    freq_unlock = 1'b0;
    reg_addr = 32'h0000_0000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    t_regs;
    t_aux;
    t_straps;
    t_align(2'h3, 6);
    t_align(2'h0, 134);
    t_align(2'h1, 18);
    t_align(2'h2, 8);
    t_auto(3'h7, 1'b0, 0);
    t_auto(3'h4, 1'b0, e_full);
    t_auto(3'h4, 1'b1, e_full);
    complete_run;
  end
  // Whole run needs about 50000 cycles
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    complete_run;
  end
endmodule // test_audio_clock_strap_and_phase_align
`default_nettype wire
